// ===== shared/pic_ocw_pkg.sv
// constants, command layouts and state types for the operation-command decode block
// Summary of operation
// - bits 4-3 = 00 selects priority/EOI command
// - code 010 does nothing; 000, 100 reserved
// - 001 non-specific EOI; 101 adds rotation
// - 011 clears in-service of selected level
// - 110 sets priority from selected level
// - 111 specific EOI plus rotation
// - level field used only when bit 6 set
// - bits 4-3 = 01 selects mode command
// - bit 5 enables loading mask mode from bit 6
// - poll bit makes next read an acknowledge
// - bits 1-0: 10 pending, 11 in-service readback
// - readback selection retained across reads
// - poll byte bit 7 flags a request
// - poll byte bits 2-0 carry highest level
// - in-service bit held from acknowledge to EOI
// - in-service blocks equal and lower priority; in special mask mode it blocks only its own level
package pic_ocw_pkg;
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] MASK_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [1:0] SEL_PRIORITY = 2'h0;
  localparam logic [1:0] SEL_MODE = 2'h1;
  localparam logic [2:0] CODE_NS_EOI = 3'h1;
  localparam logic [2:0] CODE_NOP = 3'h2;
  localparam logic [2:0] CODE_SP_EOI = 3'h3;
  localparam logic [2:0] CODE_ROT_NS_EOI = 3'h5;
  localparam logic [2:0] CODE_SET_PRIO = 3'h6;
  localparam logic [2:0] CODE_ROT_SP_EOI = 3'h7;
  localparam logic [1:0] READ_PENDING = 2'h2;
  localparam logic [1:0] READ_IN_SERVICE = 2'h3;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [2:0] LOWEST_RESET = 3'h7;
  localparam logic [3:0] POLL_FILL = 4'h0;

  typedef struct packed {
    logic [2:0] code;
    logic [1:0] select;
    logic [2:0] level;
  } prio_cmd_type;

  typedef struct packed {
    logic reserved;
    logic specialMaskSelect;
    logic maskModeWriteEnable;
    logic [1:0] select;
    logic poll;
    logic [1:0] readSelect;
  } mode_cmd_type;

  typedef struct packed {
    logic specialMask;
    logic pollPending;
    logic readInService;
    logic [2:0] lowestLevel;
  } mode_state_type;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_type;
endpackage

// ===== hw/pic_ocw_decode.sv
// operation-command decode, priority and in-service logic of one 8-level controller
`timescale 1ns/100ps
`default_nettype none

module pic_ocw_decode (
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [7:0] pendingRequest, // pending-request register
  input wire logic intAck, // acknowledge pulse
  output logic intReq, // interrupt request out
  output logic [2:0] intLevel, // level of intReq
  output logic [7:0] inService, // in-service register
  output logic [7:0] mask, // mask register
  output logic specialMaskMode // special mask mode active
);
  import pic_ocw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // priority helpers

  // returns {found, level}; scan runs from lowest to highest priority, last hit wins
  function automatic logic [3:0] topLevel(input logic [7:0] vec,
                                          input logic [2:0] lowest);
    logic [2:0] idx;
    logic [3:0] res;
    res = 4'h0;
    for (int i = 8; i >= 1; i--) begin
      idx = lowest + 3'(i);
      if (vec[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  // levels that may still raise a request given what is in service
  function automatic logic [7:0] allowMask(input logic [7:0] in_service_register,
                                           input logic [2:0] lowest,
                                           input logic special);
    logic [2:0] idx;
    logic stop;
    logic [7:0] allow;
    stop = 1'b0;
    allow = 8'h00;
    for (int i = 1; i <= 8; i++) begin
      idx = lowest + 3'(i);
      if (special) begin
        allow[idx] = ~in_service_register[idx];
      end else begin
        if (in_service_register[idx]) begin
          stop = 1'b1;
        end
        allow[idx] = ~stop;
      end
    end
    return allow;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: every access answers on the second cycle

  bus_state_type busState;
  mode_state_type mode;
  logic accept;
  logic doWrite;
  logic doRead;
  logic cmdWrite;
  logic isPrio;
  logic isMode;
  logic pollRead;
  logic ackNow;
  prio_cmd_type prioCmd;
  mode_cmd_type modeCmd;
  logic [7:0] candidates;
  logic [3:0] reqTop;
  logic [3:0] isrTop;
  logic [7:0] next_inService;
  logic [2:0] next_lowest;

  assign avs_waitrequest = (avs_read | avs_write) & (busState == BUS_IDLE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busState <= BUS_IDLE;
    end else begin
      unique case (busState)
        BUS_IDLE: begin
          if (avs_read | avs_write) begin
            busState <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          busState <= BUS_IDLE;
        end
      endcase
    end
  end

  // master holds the request until waitrequest drops, so it is still valid here
  assign accept = busState == BUS_ANSWER;
  assign doWrite = accept & avs_write;
  assign doRead = accept & avs_read;
  assign cmdWrite = doWrite & (avs_address == CMD_OFFSET) & avs_byteenable[0];
  assign prioCmd = prio_cmd_type'(avs_writedata[7:0]);
  assign modeCmd = mode_cmd_type'(avs_writedata[7:0]);
  assign isPrio = cmdWrite & (prioCmd.select == SEL_PRIORITY);
  assign isMode = cmdWrite & (modeCmd.select == SEL_MODE);

  ////////////////////////////////////////////////////////////////////////////////
  // request selection

  assign candidates = pendingRequest & ~mask
    & allowMask(inService, mode.lowestLevel, mode.specialMask);
  assign reqTop = topLevel(candidates, mode.lowestLevel);
  assign isrTop = topLevel(inService, mode.lowestLevel);

  // any read while poll is pending counts as the acknowledge
  assign pollRead = doRead & mode.pollPending;
  assign ackNow = reqTop[3] & (intAck | pollRead);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      intReq <= 1'b0;
      intLevel <= 3'h0;
    end else begin
      intReq <= reqTop[3];
      intLevel <= reqTop[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // end-of-interrupt and rotation

  always_comb begin
    next_inService = inService;
    next_lowest = mode.lowestLevel;
    if (isPrio) begin
      unique case (prioCmd.code)
        CODE_NS_EOI, CODE_ROT_NS_EOI: begin
          if (isrTop[3]) begin
            next_inService[isrTop[2:0]] = 1'b0;
            if (prioCmd.code == CODE_ROT_NS_EOI) begin
              next_lowest = isrTop[2:0];
            end
          end
        end
        CODE_SP_EOI, CODE_ROT_SP_EOI: begin
          next_inService[prioCmd.level] = 1'b0;
          if (prioCmd.code == CODE_ROT_SP_EOI) begin
            next_lowest = prioCmd.level;
          end
        end
        CODE_SET_PRIO: begin
          next_lowest = prioCmd.level;
        end
        default: begin
          // no-operation and reserved codes leave everything alone
        end
      endcase
    end
    // acknowledge wins over a clear of the same bit
    if (ackNow) begin
      next_inService[reqTop[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      inService <= 8'h00;
    end else begin
      inService <= next_inService;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode, readback selection and mask

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode.specialMask <= 1'b0;
      mode.pollPending <= 1'b0;
      mode.readInService <= 1'b0;
      mode.lowestLevel <= LOWEST_RESET;
    end else begin
      mode.lowestLevel <= next_lowest;
      if (isMode) begin
        if (modeCmd.maskModeWriteEnable) begin
          mode.specialMask <= modeCmd.specialMaskSelect;
        end
        if (modeCmd.readSelect[1]) begin
          mode.readInService <= modeCmd.readSelect[0];
        end
        mode.pollPending <= modeCmd.poll;
      end else if (pollRead) begin
        mode.pollPending <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask <= MASK_RESET;
    end else if (doWrite && avs_address == MASK_OFFSET && avs_byteenable[0]) begin
      mask <= avs_writedata[7:0];
    end
  end

  assign specialMaskMode = mode.specialMask;

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured when the request first appears

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (busState == BUS_IDLE && avs_read) begin
      if (mode.pollPending) begin
        avs_readdata <= {24'h0, reqTop[3], POLL_FILL, reqTop[2:0]};
      end else begin
        unique case (avs_address)
          CMD_OFFSET: begin
            avs_readdata <= {24'h0, mode.readInService ? inService : pendingRequest};
          end
          MASK_OFFSET: begin
            avs_readdata <= {24'h0, mask};
          end
          STATUS_OFFSET: begin
            avs_readdata <= {26'h0, mode};
          end
          default: begin
            avs_readdata <= 32'h0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence sRequestSeen;
    (avs_read || avs_write) && busState == BUS_IDLE;
  endsequence

  sequence sAnswered;
    !avs_waitrequest;
  endsequence

  sequence sPollRead;
    avs_read && busState == BUS_IDLE && mode.pollPending;
  endsequence

  a_bus_one_wait: assert property (
    sRequestSeen |-> avs_waitrequest ##1 sAnswered)
    else $error("answer not on second cycle");

  a_nop_no_change: assert property (
    isPrio && prioCmd.code == CODE_NOP && !ackNow |=>
      $stable(inService) && $stable(mode.lowestLevel))
    else $error("no-operation code changed state");

  a_specific_eoi_clear: assert property (
    isPrio && prioCmd.code == CODE_SP_EOI && !ackNow |=>
      !inService[$past(prioCmd.level)])
    else $error("specific EOI left bit set");

  a_nonspec_eoi_top: assert property (
    isPrio && prioCmd.code == CODE_NS_EOI && isrTop[3] && !ackNow |=>
      !inService[$past(isrTop[2:0])] && $stable(mode.lowestLevel))
    else $error("non-specific EOI wrong");

  a_rotate_specific: assert property (
    isPrio && prioCmd.code == CODE_ROT_SP_EOI |=>
      mode.lowestLevel == $past(prioCmd.level))
    else $error("rotate on specific EOI wrong");

  a_set_priority: assert property (
    isPrio && prioCmd.code == CODE_SET_PRIO && !ackNow |=>
      mode.lowestLevel == $past(prioCmd.level) && $stable(inService))
    else $error("set priority wrong");

  a_mask_mode_load: assert property (
    isMode |=> mode.specialMask ==
      ($past(modeCmd.maskModeWriteEnable) ? $past(modeCmd.specialMaskSelect)
                                         : $past(mode.specialMask)))
    else $error("mask mode load wrong");

  // checked on every capture, not only right after the mode write
  a_readback_select: assert property (
    busState == BUS_IDLE && avs_read && !mode.pollPending && avs_address == CMD_OFFSET
      && mode.readInService |=> avs_readdata[7:0] == $past(inService))
    else $error("in-service readback wrong");

  a_poll_byte: assert property (
    sPollRead |=> avs_readdata[7] == $past(reqTop[3])
      && avs_readdata[2:0] == $past(reqTop[2:0]) ##0 sAnswered)
    else $error("poll byte wrong");

  a_poll_ends: assert property (
    sPollRead ##1 avs_read |=> !mode.pollPending)
    else $error("poll stayed pending");

  a_block_lower: assert property (
    reqTop[3] && !mode.specialMask && isrTop[3] |->
      !inService[reqTop[2:0]]
      && 3'(reqTop[2:0] - mode.lowestLevel - 3'h1) < 3'(isrTop[2:0] - mode.lowestLevel - 3'h1))
    else $error("lower request not blocked");

endmodule // pic_ocw_decode

`default_nettype wire

// ===== bench/pic_request_source.sv
// request source model standing in for the resolver logic beside the block
`timescale 1ns/100ps
`default_nettype none

module pic_request_source (
  input wire logic sys_clk, // system clock
  input wire logic [7:0] wantPending, // pending pattern asked by the bench
  input wire logic ackGo, // acknowledge asked by the bench
  input wire logic intReq, // request seen from the block
  output logic [7:0] pendingRequest, // pending-request register
  output logic intAck // one-cycle acknowledge pulse
);
  always_ff @(posedge sys_clk) begin
    pendingRequest <= wantPending;
  end

  // a real resolver only acknowledges a raised request, once
  always_ff @(posedge sys_clk) begin
    intAck <= ackGo & intReq & ~intAck;
  end
endmodule // pic_request_source

`default_nettype wire

// ===== bench/pic_ocw_decode_test.sv
// self-checking bench for the operation-command decode block
`timescale 1ns/100ps
`default_nettype none

module pic_ocw_decode_test;
  import pic_ocw_pkg::*;
  logic sysClk = 1'b0;
  logic rstN = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [31:0] avsReadData;
  logic avsWait;
  logic [7:0] wantPending = 8'h00;
  logic ackGo = 1'b0;
  logic [7:0] pendingRequest;
  logic intAck;
  logic intReq;
  logic [2:0] intLevel;
  logic [7:0] inService;
  logic [7:0] mask;
  logic specialMaskMode;
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] got;
  logic [7:0] idleCmd [4] = '{8'h00, 8'h40, 8'h80, 8'h18};
  logic [7:0] modeCmd [4] = '{8'h68, 8'h48, 8'h28, 8'h08};
  logic [7:0] smmExp [4] = '{8'h01, 8'h01, 8'h00, 8'h00};

  always #2 sysClk = ~sysClk;

  pic_ocw_decode u_dut (
    .sys_clk(sysClk),
    .rst_n(rstN),
    .avs_address(avsAddress),
    .avs_read(avsRead),
    .avs_write(avsWrite),
    .avs_writedata(avsWriteData),
    .avs_byteenable(4'hF),
    .avs_readdata(avsReadData),
    .avs_waitrequest(avsWait),
    .pendingRequest(pendingRequest),
    .intAck(intAck),
    .intReq(intReq),
    .intLevel(intLevel),
    .inService(inService),
    .mask(mask),
    .specialMaskMode(specialMaskMode)
  );

  pic_request_source u_source (
    .sys_clk(sysClk),
    .wantPending(wantPending),
    .ackGo(ackGo),
    .intReq(intReq),
    .pendingRequest(pendingRequest),
    .intAck(intAck)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic compare(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge sysClk);
    avsAddress <= a;
    avsWriteData <= {24'h000000, d};
    avsWrite <= wr;
    avsRead <= ~wr;
    do begin
      @(posedge sysClk);
      n++;
    end while (avsWait !== 1'b0 && n < 20);
    if (avsWait !== 1'b0) begin
      failures++;
      summarize();
    end else begin
      got = avsReadData[7:0];
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
    end
  endtask

  task automatic checkReg(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    compare(got, e);
  endtask

  // outputs follow their cause within a cycle or two
  task automatic checkPin(input int sel, input logic [7:0] e);
    repeat (3) @(posedge sysClk);
    #1;
    case (sel)
      0: compare(inService, e);
      1: compare({7'h00, intReq}, e);
      2: compare({5'h00, intLevel}, e);
      3: compare({7'h00, specialMaskMode}, e);
      default: compare(mask, e);
    endcase
  endtask

  task automatic ack();
    @(posedge sysClk);
    ackGo <= 1'b1;
    @(posedge sysClk);
    ackGo <= 1'b0;
    repeat (3) @(posedge sysClk);
  endtask

  task automatic setPend(input logic [7:0] v);
    @(posedge sysClk);
    wantPending <= v;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sysClk);
    rstN <= 1'b1;
    checkReg(STATUS_OFFSET, 8'h07);
    checkReg(MASK_OFFSET, 8'hFF);
    bus(1'b1, MASK_OFFSET, 8'h00);
    checkPin(4, 8'h00);
    checkReg(CMD_OFFSET, 8'h00);
    setPend(8'h28);
    checkReg(CMD_OFFSET, 8'h28);
    checkReg(CMD_OFFSET, 8'h28);
    checkPin(1, 8'h01);
    checkPin(2, 8'h03);
    ack();
    checkPin(0, 8'h08);
    checkPin(1, 8'h00);
    bus(1'b1, CMD_OFFSET, 8'h0B);
    checkReg(CMD_OFFSET, 8'h08);
    bus(1'b1, CMD_OFFSET, 8'h09);
    checkReg(CMD_OFFSET, 8'h08);
    setPend(8'h2A);
    checkPin(1, 8'h01);
    checkPin(2, 8'h01);
    $display("test readback done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, CMD_OFFSET, idleCmd[i]);
      checkPin(0, 8'h08);
      checkReg(STATUS_OFFSET, 8'h0F);
    end
    ack();
    checkPin(0, 8'h0A);
    // level field 3 must be ignored: top in-service is level 1
    bus(1'b1, CMD_OFFSET, 8'h23);
    checkPin(0, 8'h08);
    bus(1'b1, CMD_OFFSET, 8'h63);
    checkPin(0, 8'h00);
    ack();
    bus(1'b1, CMD_OFFSET, 8'hA0);
    checkPin(0, 8'h00);
    checkReg(STATUS_OFFSET, 8'h09);
    bus(1'b1, CMD_OFFSET, 8'hC4);
    checkReg(STATUS_OFFSET, 8'h0C);
    checkPin(2, 8'h05);
    ack();
    checkPin(0, 8'h20);
    bus(1'b1, CMD_OFFSET, 8'hE5);
    checkPin(0, 8'h00);
    checkReg(STATUS_OFFSET, 8'h0D);
    $display("test commands done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, CMD_OFFSET, modeCmd[i]);
      checkPin(3, smmExp[i]);
    end
    $display("test mask mode done");
    // lowest is 5, so level 1 outranks 3 and 5
    bus(1'b1, CMD_OFFSET, 8'h0C);
    checkReg(MASK_OFFSET, 8'h81);
    checkPin(0, 8'h02);
    checkReg(MASK_OFFSET, 8'h00);
    bus(1'b1, CMD_OFFSET, 8'h20);
    setPend(8'h00);
    bus(1'b1, CMD_OFFSET, 8'h0C);
    bus(1'b0, STATUS_OFFSET, 8'h00);
    compare(got & 8'h80, 8'h00);
    $display("test poll done");
    // special mask: level 1 in service no longer blocks level 3
    setPend(8'h0A);
    checkPin(1, 8'h01);
    ack();
    checkPin(0, 8'h02);
    checkPin(1, 8'h00);
    bus(1'b1, CMD_OFFSET, 8'h68);
    checkPin(1, 8'h01);
    checkPin(2, 8'h03);
    $display("test special mask done");
    summarize();
  end
endmodule // pic_ocw_decode_test

`default_nettype wire
